// *** include/pmc_defs.vh ***
// Register map, field positions, reset values and timing constants of the power and clock control block
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
`define PMC_ADDR_W 16
`define PMC_CTRL_OFFSET 16'h0020
`define PMC_CTRL_RESET 8'h00
`define PMC_BIT_SLOW 0
`define PMC_BIT_PSM_LO 1
`define PMC_BIT_PSM_HI 2
`define PMC_BIT_POL01_LO 3
`define PMC_BIT_POL01_HI 4
`define PMC_BIT_CLKOUT 5
`define PMC_BIT_POL23_LO 6
`define PMC_BIT_POL23_HI 7
`define PMC_POL_FALL_LOW 2'h0
`define PMC_POL_RISE 2'h1
`define PMC_POL_FALL 2'h2
`define PMC_POL_BOTH 2'h3
`define PMC_STARTUP_CYCLES 4096
`endif

// *** src/pmc_ctrl.v ***
// Power saving modes, slow clock prescaler, external interrupt polarity and clock output
`timescale 1ns/1ns
`include "pmc_defs.vh"
// Functional notes
// - Slow mode divides oscillator by 4,16,8,32
// - Slow clock enable drives CPU and peripherals
// - Control register resets to zero, divide by 2
// - Wait/stop by instruction; slow by register
// - Wait stops CPU, clears mask, peripherals run
// - Wait ends on interrupt or reset
// - Stop turns oscillator and everything off
// - Stop with watchdog enabled gives reset
// - Stop entry clears interrupt mask bit
// - Stop wake holds CPU 4096 clock cycles
// - After delay, service interrupt or reset vector; wake_reset_out stays 0 here, as wake_by_reset_q is never set
// - Service pushes flags, sets mask during routine
// - Bits 7:6 select vector two/three trigger
// - Bits 4:3 select vector zero/one trigger
// - Polarity change clears related pending request
// - Bit 5 drives CPU clock on pin
// - Vector pins ANDed before edge detection
// - Output pins never raise interrupts
// - Edge requests latch, clear on service entry
// - Any interrupt wakes wait; external wakes stop
module pmc_ctrl #(
    parameter PIN_W = 4,
    parameter STARTUP_CYCLES = `PMC_STARTUP_CYCLES
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Register port
    input wire [`PMC_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    // CPU instruction and status
    input wire wait_instr_in,
    input wire stop_instr_in,
    input wire watchdog_en_in,
    input wire [3:0] ext_ack_in,
    input wire other_irq_in,
    input wire other_stop_wake_in,
    input wire flags_push_in,
    input wire flags_pop_in,
    // External interrupt pin groups, one group of PIN_W per vector
    input wire [4*PIN_W-1:0] ext_pin_in,
    input wire [4*PIN_W-1:0] ext_pin_is_out_in,
    input wire [4*PIN_W-1:0] ext_pin_irq_en_in,
    // Clocking and mode outputs
    output reg cpu_clk_en_out,
    output reg cpu_clk_out,
    output reg clock_output_pin_out,
    output reg clkout_sel_out,
    output reg osc_on_out,
    output reg cpu_run_out,
    output reg wait_mode_out,
    output reg stop_mode_out,
    output reg wdg_reset_out,
    output reg irq_mask_out,
    output reg wake_reset_out,
    output reg [3:0] ext_req_out
);

    // ------------------------------------------------------------
    // Local definitions
    // ------------------------------------------------------------
    localparam ST_RUN = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_STOP = 2'h2;
    localparam ST_START = 2'h3;
    localparam [12:0] START_LAST = STARTUP_CYCLES - 1;

    // Divide ratio as a terminal count of a free running counter
    function [4:0] div_last;
        input [7:0] ctrl;
        begin
            if (!ctrl[`PMC_BIT_SLOW])
                div_last = 5'h01;
            else begin
                case (ctrl[`PMC_BIT_PSM_HI:`PMC_BIT_PSM_LO])
                    2'h0: div_last = 5'h03;
                    2'h1: div_last = 5'h0f;
                    2'h2: div_last = 5'h07;
                    default: div_last = 5'h1f;
                endcase
            end
        end
    endfunction

    reg [7:0] ctrl_q;
    reg [1:0] state_q;
    reg [12:0] start_cnt_q;
    reg [4:0] div_q;
    reg [3:0] comb_q;
    reg [3:0] pend_q;
    reg wake_by_reset_q;
    wire reg_hit = (addr_in == `PMC_CTRL_OFFSET);
    wire ctrl_wr = wr_in && reg_hit;
    wire [3:0] comb_d;
    wire [3:0] pol_chg;
    wire [1:0] pol01 = ctrl_q[`PMC_BIT_POL01_HI:`PMC_BIT_POL01_LO];
    wire [1:0] pol23 = ctrl_q[`PMC_BIT_POL23_HI:`PMC_BIT_POL23_LO];
    wire [4:0] last = div_last(ctrl_q);
    wire tick = (div_q >= last);
    wire any_ext = |pend_q;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always @(posedge clock_in) begin
        if (rst_in)
            ctrl_q <= `PMC_CTRL_RESET;
        else if (ctrl_wr)
            ctrl_q <= wdata_in;
    end

    always @(posedge clock_in) begin
        if (rst_in)
            rdata_out <= 8'h00;
        else if (rd_in && reg_hit)
            rdata_out <= ctrl_q;
        else
            rdata_out <= 8'h00;
    end

    assign pol_chg[0] = ctrl_wr &&
        (wdata_in[`PMC_BIT_POL01_HI:`PMC_BIT_POL01_LO] != pol01);
    assign pol_chg[1] = pol_chg[0];
    assign pol_chg[2] = ctrl_wr &&
        (wdata_in[`PMC_BIT_POL23_HI:`PMC_BIT_POL23_LO] != pol23);
    assign pol_chg[3] = pol_chg[2];

    // ------------------------------------------------------------
    // External interrupt detection
    // ------------------------------------------------------------
    genvar v;
    generate
        for (v = 0; v < 4; v = v + 1) begin : g_vec
            wire [PIN_W-1:0] pins = ext_pin_in[v*PIN_W +: PIN_W];
            wire [PIN_W-1:0] use_pin = ext_pin_irq_en_in[v*PIN_W +: PIN_W] &
                ~ext_pin_is_out_in[v*PIN_W +: PIN_W];
            // Pins not taking part read as high so they never mask others
            assign comb_d[v] = &(pins | ~use_pin);
            wire [1:0] pol = (v < 2) ? pol01 : pol23;
            wire fall = comb_q[v] && !comb_d[v];
            wire rise = !comb_q[v] && comb_d[v];
            reg hit;
            always @* begin
                case (pol)
                    `PMC_POL_FALL_LOW: hit = !comb_d[v];
                    `PMC_POL_RISE: hit = rise;
                    `PMC_POL_FALL: hit = fall;
                    default: hit = rise || fall;
                endcase
            end
            // Polarity change clears; a new event still sets in the same cycle
            always @(posedge clock_in) begin
                if (rst_in)
                    pend_q[v] <= 1'b0;
                else if (hit)
                    pend_q[v] <= 1'b1;
                else if (pol_chg[v] || ext_ack_in[v])
                    pend_q[v] <= 1'b0;
            end
        end
    endgenerate

    always @(posedge clock_in) begin
        if (rst_in) begin
            comb_q <= 4'hf;
            ext_req_out <= 4'h0;
        end else begin
            comb_q <= comb_d;
            ext_req_out <= pend_q & ~(ext_ack_in | pol_chg);
        end
    end

    // ------------------------------------------------------------
    // Power mode sequencer
    // ------------------------------------------------------------
    always @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= ST_RUN;
            start_cnt_q <= 13'h0000;
            irq_mask_out <= 1'b0;
            wdg_reset_out <= 1'b0;
            wake_by_reset_q <= 1'b0;
            wake_reset_out <= 1'b0;
        end else begin
            wdg_reset_out <= 1'b0;
            wake_reset_out <= 1'b0;
            if (flags_push_in)
                irq_mask_out <= 1'b1;
            else if (flags_pop_in)
                irq_mask_out <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (stop_instr_in && watchdog_en_in)
                        wdg_reset_out <= 1'b1;
                    else if (stop_instr_in) begin
                        state_q <= ST_STOP;
                        irq_mask_out <= 1'b0;
                    end else if (wait_instr_in) begin
                        state_q <= ST_WAIT;
                        irq_mask_out <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (any_ext || other_irq_in)
                        state_q <= ST_RUN;
                end
                ST_STOP: begin
                    if (any_ext || other_stop_wake_in) begin
                        state_q <= ST_START;
                        start_cnt_q <= 13'h0000;
                        wake_by_reset_q <= 1'b0;
                    end
                end
                ST_START: begin
                    // Release on the last CPU clock tick, so the hold spans the full count
                    if (tick) begin
                        if (start_cnt_q >= START_LAST) begin
                            state_q <= ST_RUN;
                            wake_reset_out <= wake_by_reset_q;
                        end else
                            start_cnt_q <= start_cnt_q + 13'h0001;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------
    // The divider is cleared and held at zero in stop mode, as the oscillator is off
    always @(posedge clock_in) begin
        if (rst_in) begin
            div_q <= 5'h00;
            cpu_clk_en_out <= 1'b0;
            cpu_clk_out <= 1'b0;
        end else if (state_q == ST_STOP) begin
            div_q <= 5'h00;
            cpu_clk_en_out <= 1'b0;
            cpu_clk_out <= 1'b0;
        end else begin
            div_q <= tick ? 5'h00 : div_q + 5'h01;
            cpu_clk_en_out <= tick;
            cpu_clk_out <= (div_q < ((last + 5'h01) >> 1)) ? 1'b0 : 1'b1;
        end
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            clock_output_pin_out <= 1'b0;
            clkout_sel_out <= 1'b0;
            osc_on_out <= 1'b1;
            cpu_run_out <= 1'b1;
            wait_mode_out <= 1'b0;
            stop_mode_out <= 1'b0;
        end else begin
            clkout_sel_out <= ctrl_q[`PMC_BIT_CLKOUT];
            clock_output_pin_out <= ctrl_q[`PMC_BIT_CLKOUT] && cpu_clk_out;
            osc_on_out <= (state_q != ST_STOP);
            cpu_run_out <= (state_q == ST_RUN);
            wait_mode_out <= (state_q == ST_WAIT);
            stop_mode_out <= (state_q == ST_STOP);
        end
    end

endmodule // pmc_ctrl

// *** testbench/pmc_pin_model.sv ***
// Model of the external interrupt pin groups
`timescale 1ns/1ns
module pmc_pin_model #(parameter PIN_W = 4) (
    // Commands
    input wire clock_in,
    input wire [3:0] level_in,
    input wire hold_low_in,
    // Pins
    output reg [4*PIN_W-1:0] ext_pin_out
);
    integer v;
    initial ext_pin_out = {4*PIN_W{1'b1}};
    // Pins move one edge late, as a board behind the oscillator would
    always @(posedge clock_in) begin
        for (v = 0; v < 4; v = v + 1) begin
            ext_pin_out[v*PIN_W +: PIN_W] <= {PIN_W{level_in[v]}};
        end
        // A stuck-low pin of vector one masks its whole group
        if (hold_low_in) begin
            ext_pin_out[PIN_W] <= 1'b0;
        end
    end
endmodule // pmc_pin_model

// *** testbench/pmc_ctrl_monitor.sv ***
// Port checker of the power and clock control block
`timescale 1ns/1ns
`include "pmc_defs.vh"
module pmc_monitor #(parameter PIN_W = 4, parameter STARTUP_CYCLES = 8) (
    // Watched ports
    input wire clock_in, rst_in, wr_in, rd_in, wait_instr_in, stop_instr_in, watchdog_en_in,
    input wire [`PMC_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in, rdata_out,
    input wire [4*PIN_W-1:0] ext_pin_in, ext_pin_is_out_in, ext_pin_irq_en_in,
    input wire cpu_clk_en_out, clock_output_pin_out, clkout_sel_out, osc_on_out, cpu_run_out,
    input wire wait_mode_out, stop_mode_out, irq_mask_out, wdg_reset_out,
    input wire [3:0] ext_req_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    reg [7:0] ctrl_q;
    reg [5:0] gap_q;
    reg odd_q;
    wire hit = wr_in && addr_in == `PMC_CTRL_OFFSET;
    wire low0 = ~&(ext_pin_in[PIN_W-1:0] | ext_pin_is_out_in[PIN_W-1:0] | ~ext_pin_irq_en_in[PIN_W-1:0]);
    wire [1:0] psm = ctrl_q[2:1];
    wire [5:0] div = !ctrl_q[0] ? 6'h02 : psm == 2'h0 ? 6'h04 : psm == 2'h1 ? 6'h10 : psm == 2'h2 ? 6'h08 : 6'h20;
    // ---------------------------------------------
    // Helper state
    // ---------------------------------------------
    // An interval cut by a divisor change or a stop is skipped
    always @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_q <= `PMC_CTRL_RESET;
            odd_q <= 1'b1;
        end else begin
            if (hit) ctrl_q <= wdata_in;
            if ((hit && wdata_in[2:0] != ctrl_q[2:0]) || stop_mode_out) odd_q <= 1'b1;
            else if (cpu_clk_en_out) odd_q <= 1'b0;
        end
        gap_q <= cpu_clk_en_out ? 6'h01 : gap_q + 6'h01;
    end
    clk_div_a: assert property (
        cpu_clk_en_out && !odd_q |-> gap_q == div) else $error("cpu clock spacing");
    read_back_a: assert property (
        rd_in |=> rdata_out == ($past(addr_in) == `PMC_CTRL_OFFSET ? $past(ctrl_q) : 8'h00)) else $error("read data");
    wdg_stop_a: assert property (
        stop_instr_in && watchdog_en_in && cpu_run_out |=> wdg_reset_out ##1 !stop_mode_out) else $error("stop with watchdog");
    stop_entry_a: assert property (
        stop_instr_in && !watchdog_en_in && cpu_run_out |=> !irq_mask_out ##1 stop_mode_out) else $error("stop entry");
    wait_entry_a: assert property (
        wait_instr_in && cpu_run_out |=> !irq_mask_out ##1 wait_mode_out && !cpu_run_out) else $error("wait entry");
    stop_dark_a: assert property (
        stop_mode_out |-> !osc_on_out && !cpu_clk_en_out && !cpu_run_out) else $error("stop not dark");
    wait_alive_a: assert property (
        wait_mode_out |-> osc_on_out) else $error("wait stopped oscillator");
    clock_pin_a: assert property (
        (!clkout_sel_out)[*2] |-> !clock_output_pin_out) else $error("clock pin driven");
    level_req_a: assert property (
        (ctrl_q[4:3] == 2'h0 && low0)[*3] |-> ext_req_out[0]) else $error("level request lost");
    cover property (stop_mode_out ##1 !stop_mode_out);
    cover property (wait_mode_out ##1 cpu_run_out);
    cover property (ext_req_out[1] && ctrl_q[4:3] == 2'h1);
endmodule // pmc_monitor
bind pmc_ctrl pmc_monitor #(.PIN_W(PIN_W), .STARTUP_CYCLES(STARTUP_CYCLES)) pmc_mon (.*);

// *** testbench/power_mode_clock_and_ext_irq_polarity_bench.sv ***
// Self-checking bench of the power and clock control block
`timescale 1ns/1ns
`include "pmc_defs.vh"
module power_mode_clock_and_ext_irq_polarity_bench;
    reg clock_in, rst_in, wr_in, rd_in, wait_instr_in, stop_instr_in, watchdog_en_in, other_irq_in;
    reg other_stop_wake_in, flags_push_in, flags_pop_in, hold;
    reg [15:0] addr_in, ext_pin_is_out_in, ext_pin_irq_en_in;
    reg [7:0] wdata_in, d;
    reg [3:0] ext_ack_in, lvl;
    wire [15:0] ext_pin_in;
    wire [7:0] rdata_out;
    wire [3:0] ext_req_out;
    wire cpu_clk_en_out, cpu_clk_out, clock_output_pin_out, clkout_sel_out, osc_on_out, cpu_run_out;
    wire wait_mode_out, stop_mode_out, wdg_reset_out, irq_mask_out, wake_reset_out;
    integer err_total, checked, seed, i, n, k;
    localparam [15:0] A = `PMC_CTRL_OFFSET;
    pmc_ctrl #(.PIN_W(4), .STARTUP_CYCLES(8)) dut (.*);
    pmc_pin_model #(.PIN_W(4)) pins (.clock_in(clock_in), .level_in(lvl), .hold_low_in(hold), .ext_pin_out(ext_pin_in));
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %h, not %h", $time, seen, exp);
            end
        end
    endtask
    // Samples land 1 ns after the edge, so no race with the design
    task tick(input integer c);
        repeat (c) begin @(posedge clock_in); #1; end
    endtask
    task bus(input w, input [15:0] a, input [7:0] v);
        begin
            addr_in <= a; wdata_in <= v; wr_in <= w; rd_in <= !w;
            tick(1);
            wr_in <= 1'b0; rd_in <= 1'b0;
            if (!w) chk(rdata_out, v);
            tick(1);
        end
    endtask
    task ack(input [3:0] m);
        begin ext_ack_in <= m; tick(1); ext_ack_in <= 4'h0; tick(2); end
    endtask
    task print_verdict;
        begin
            $display("checked %0d err_total %0d", checked, err_total);
            if (err_total == 0 && checked > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        {rst_in, wr_in, rd_in, wait_instr_in, stop_instr_in, watchdog_en_in, other_irq_in} = 7'h01 << 6;
        {other_stop_wake_in, flags_push_in, flags_pop_in, hold, ext_ack_in} = 8'h00;
        {addr_in, wdata_in, ext_pin_is_out_in} = 40'h0;
        ext_pin_irq_en_in = 16'hffff; lvl = 4'hf; seed = 32'h49e2; err_total = 0; checked = 0;
        tick(16);
        rst_in <= 1'b0;
        tick(1);
        bus(0, A, `PMC_CTRL_RESET);
        // Every prescaler code first, then random values; spacing is judged by the monitor
        for (i = 0; i < 14; i = i + 1) begin
            d = (i < 8) ? 8'(i * 37) : 8'($random(seed));
            bus(1, A, d);
            bus(1, 16'h0021, ~d);
            bus(0, A, d);
            bus(0, 16'h0021, 8'h00);
            chk(8'(clkout_sel_out), 8'(d[5]));
            tick(70);
        end
        bus(1, A, 8'h00); lvl <= 4'he; tick(4);
        chk(8'(ext_req_out[0]), 8'h01);
        lvl <= 4'hf; tick(3); ack(4'h1);
        chk(8'(ext_req_out[0]), 8'h00);
        bus(1, A, 8'h08); lvl <= 4'he; tick(3); lvl <= 4'hf; tick(8);
        chk(8'(ext_req_out[0]), 8'h01);
        bus(1, A, 8'h10);
        chk(8'(ext_req_out[0]), 8'h00);
        bus(1, A, 8'h08); hold <= 1'b1; lvl <= 4'hd; tick(3); lvl <= 4'hf; tick(4);
        chk(8'(ext_req_out[1]), 8'h00);
        hold <= 1'b0; tick(4);
        chk(8'(ext_req_out[1]), 8'h01);
        ack(4'h2); bus(1, A, 8'h00); ext_pin_is_out_in <= 16'h00f0; tick(1); lvl <= 4'hd; tick(4);
        chk(8'(ext_req_out[1]), 8'h00);
        lvl <= 4'hf; tick(3); ext_pin_is_out_in <= 16'h0000; bus(1, A, 8'h80); lvl <= 4'h3; tick(4);
        chk(8'(ext_req_out), 8'h0c);
        ack(4'hc);
        chk(8'(ext_req_out), 8'h00);
        lvl <= 4'hf; bus(1, A, 8'h00); watchdog_en_in <= 1'b1; stop_instr_in <= 1'b1; tick(1);
        stop_instr_in <= 1'b0; tick(2);
        chk(8'(stop_mode_out), 8'h00);
        watchdog_en_in <= 1'b0; stop_instr_in <= 1'b1; tick(1); stop_instr_in <= 1'b0; tick(1);
        chk(8'(stop_mode_out), 8'h01);
        tick(20); lvl <= 4'he; n = 0; k = 0;
        while (cpu_run_out !== 1'b1 && n < 400) begin
            if (stop_mode_out === 1'b0 && cpu_clk_en_out === 1'b1) k = k + 1;
            tick(1); n = n + 1;
        end
        chk(8'(n < 400 && k >= 8 && k <= 9), 8'h01);
        lvl <= 4'hf; tick(3); ack(4'h1); wait_instr_in <= 1'b1; tick(1); wait_instr_in <= 1'b0; tick(10);
        chk(8'(cpu_run_out), 8'h00);
        other_irq_in <= 1'b1; n = 0;
        while (cpu_run_out !== 1'b1 && n < 20) begin tick(1); n = n + 1; end
        other_irq_in <= 1'b0;
        chk(8'(n < 20 && wait_mode_out === 1'b0), 8'h01);
        flags_push_in <= 1'b1; tick(1); flags_push_in <= 1'b0;
        chk(8'(irq_mask_out), 8'h01);
        flags_pop_in <= 1'b1; tick(1); flags_pop_in <= 1'b0;
        chk(8'(irq_mask_out), 8'h00);
        print_verdict;
    end
endmodule // power_mode_clock_and_ext_irq_polarity_bench
